// *** inc/lblank_params.svh ***
/*
  Constants of the local blanking control block: register indexes,
  field positions and reset values.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef LBLANK_PARAMS_SVH
`define LBLANK_PARAMS_SVH

`define LB_NUM_IN       16
`define LB_CARD_SEL     4'h0
`define LB_REG_EN_LO    4'h0
`define LB_REG_EN_HI    4'h1
`define LB_REG_POL_LO   4'h2
`define LB_REG_POL_HI   4'h3
`define LB_REG_STATUS   4'h4
`define LB_REG_IN_LO    4'h5
`define LB_REG_IN_HI    4'h6
`define LB_REG_CTRL     4'h7
`define LB_REG_ACT_LO   4'h8
`define LB_REG_ACT_HI   4'h9
`define LB_REG_CNT_LO   4'ha
`define LB_REG_CNT_HI   4'hb
`define LB_CTRL_RUN     0
`define LB_CTRL_INIT    1
`define LB_ST_LOCAL     0
`define LB_ST_GLOBAL    1
`define LB_ST_ACQ       2
`define LB_ST_PAUSED    3
`define LB_ST_DISABLED  4
`define LB_ST_CONN      5
`define LB_EN_RST       16'h0000
`define LB_POL_RST      16'h0000
`define LB_CONN_RST     16'h0000
`define LB_CONN_ALL     16'hffff
`define LB_CNT_RST      16'h0000
`define LB_BYTE_ZERO    8'h00
`define LB_WORD_PAD     24'h000000

`endif

// *** inc/lblank_pkg.sv ***
/*
  Types shared by the local blanking control block.
  Assumes the constants header is on the include path.
*/
`include "lblank_params.svh"

package lblank_pkg;

  typedef logic [`LB_NUM_IN-1:0] blank_vec_t;
  typedef logic [7:0]            reg_byte_t;

  typedef enum logic [1:0] {
    ACQ_IDLE,
    ACQ_RUN,
    ACQ_PAUSED,
    ACQ_DISABLED
  } acq_state_t;

endpackage : lblank_pkg

// *** inc/lblank_if.sv ***
/*
  Carrier between the blanking core and its per-input conditioners:
  settings out to the inputs, synchronised and gated levels back.
  Assumes lblank_pkg is compiled first.
*/
`timescale 1ns/100ps

interface lblank_if
  import lblank_pkg::*;
  ;
  blank_vec_t      enable;
  blank_vec_t      polarity;
  blank_vec_t      connInput;
  wire blank_vec_t synced;
  wire blank_vec_t gated;

  modport ctl  (output enable, polarity, connInput, input synced, gated);
  modport cond (input enable, polarity, connInput, output synced, gated);
endinterface : lblank_if

// *** logic/blank_input_cond.sv ***
/*
  One external inhibit input: two-stage synchroniser, polarity and
  enable gating. One instance per input bit IDX.
  Assumes the input is an asynchronous level from a front-panel connector.
*/
`timescale 1ns/100ps

module blank_input_cond
  import lblank_pkg::*;
#(
  parameter int IDX = 0
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic extIn,
  lblank_if.cond    bus
);

  logic syncFirst;
  logic syncSecond;

  // RULE13 two stage synchroniser
  always_ff @(posedge mclk) begin
    if (reset) begin
      syncFirst  <= 1'h0;
      syncSecond <= 1'h0;
    end else begin
      syncFirst  <= extIn;
      syncSecond <= syncFirst;
    end
  end

  // RULE5 active level select
  wire activeLevel = ~(syncSecond ^ bus.polarity[IDX]);

  assign bus.synced[IDX] = syncSecond;
  // RULE4 enable gates input
  assign bus.gated[IDX]  = activeLevel & bus.enable[IDX]
                         & bus.connInput[IDX];

  a_sync_two_stage: assert property (   // RULE13
    @(posedge mclk) disable iff (reset)
    ##2 (bus.synced[IDX] == $past(extIn, 2)))
    else $error("synchroniser latency is not two cycles");

  a_gate_disabled: assert property (   // RULE4
    @(posedge mclk) disable iff (reset)
    !bus.enable[IDX] |-> !bus.gated[IDX])
    else $error("disabled input reaches the common inhibit");

  a_polarity_level: assert property (   // RULE5
    @(posedge mclk) disable iff (reset)
    (bus.enable[IDX] && bus.connInput[IDX])
      |-> (bus.gated[IDX] == (bus.synced[IDX] == bus.polarity[IDX])))
    else $error("polarity does not select the active level");

endmodule : blank_input_cond

// *** logic/local_blanking_control.sv ***
/*
  Local blanking control: per-input polarity and enable, OR into one
  common local inhibit, acquisition pause/disable sequencing, and a
  classic Wishbone slave for the byte-wide register space.
  Assumes a single 10 MHz clock mclk and a synchronous active-high reset;
  globalBlank and the Wishbone signals are synchronous to mclk.
*/
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps

`include "lblank_params.svh"

// Operation
// RULE1: on initialization all connectors become inputs to the local inhibit.
// RULE2: one enable bit per input, sixteen in all, committed as one value.
// RULE3: card k supplies bits 2k (first connector) and 2k+1 (second).
// RULE4: enable 0 ignores an input, enable 1 lets it halt acquisition.
// RULE5: polarity bit per input: 1 active high, 0 active low.
// RULE6: enables and polarities read back in their written layout.
// RULE7: inputs inverted, gated and ORed into one common local inhibit.
// RULE8: acquisition pauses while the common local inhibit is asserted.
// RULE9: after local inhibit ends, acquisition resumes within the same frame.
// RULE10: global blanking disables acquisition; restart at once when it ends.
// RULE11: local inhibit has priority over global blanking.
// RULE12: 256 byte registers; upper nibble picks card, lower nibble register.
// RULE13: every external input is synchronised by two flip-flops first.
module local_blanking_control
  import lblank_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  wbCyc,
  input  wire logic                  wbStb,
  input  wire logic                  wbWe,
  input  wire logic [9:0]            wbAdr,
  input  wire logic [3:0]            wbSel,
  input  wire logic [31:0]           wbDatIn,
  output logic      [31:0]           wbDatOut,
  output logic                       wbAck,
  input  wire logic [`LB_NUM_IN-1:0] extBlank,
  input  wire logic                  globalBlank,
  output logic                       localBlank,
  output logic                       acqRun,
  output logic                       acqPaused,
  output logic                       acqDisabled,
  output logic                       integRestart,
  output logic                       frameResume,
  output logic      [`LB_NUM_IN-1:0] connInput
);

  lblank_if ifc ();

  blank_vec_t enable;
  blank_vec_t polarity;
  blank_vec_t pauseCount;
  reg_byte_t  enStage;
  reg_byte_t  polStage;
  logic       ctrlRun;
  acq_state_t state;
  acq_state_t next_state;
  logic       next_integRestart;
  logic       next_frameResume;

  // RULE3 input numbering
  for (genvar i = 0; i < `LB_NUM_IN; i++) begin : g_in
    blank_input_cond #(
      .IDX (i)
    ) u_cond (
      .mclk  (mclk),
      .reset (reset),
      .extIn (extBlank[i]),
      .bus   (ifc)
    );
  end

  assign ifc.enable    = enable;
  assign ifc.polarity  = polarity;
  assign ifc.connInput = connInput;

  // bus decode: byte register index sits on word addresses
  wire [7:0] regIdx   = wbAdr[9:2];
  wire [3:0] cardSel  = regIdx[7:4];
  wire [3:0] regSel   = regIdx[3:0];
  wire       wbReq    = wbCyc & wbStb;
  // RULE12 card then register
  wire       cardHit  = (cardSel == `LB_CARD_SEL);
  wire       wrFire   = wbReq & wbWe & wbAck & wbSel[0] & cardHit;
  wire       rdTake   = wbReq & ~wbAck;
  wire [7:0] wrByte   = wbDatIn[7:0];

  wire wrEnLo  = wrFire & (regSel == `LB_REG_EN_LO);
  wire wrEnHi  = wrFire & (regSel == `LB_REG_EN_HI);
  wire wrPolLo = wrFire & (regSel == `LB_REG_POL_LO);
  wire wrPolHi = wrFire & (regSel == `LB_REG_POL_HI);
  wire wrCtrl  = wrFire & (regSel == `LB_REG_CTRL);
  wire initCmd = wrCtrl & wrByte[`LB_CTRL_INIT];

  // status byte built from live state
  wire [7:0] statusByte = {
    2'h0,
    connInput == `LB_CONN_ALL,
    acqDisabled,
    acqPaused,
    acqRun,
    globalBlank,
    localBlank
  };

  wire [7:0] ctrlByte = {7'h00, ctrlRun};

  // RULE6 read back layout
  wire [7:0] rdByte =
    !cardHit                     ? `LB_BYTE_ZERO          :
    (regSel == `LB_REG_EN_LO)    ? enable[7:0]            :
    (regSel == `LB_REG_EN_HI)    ? enable[15:8]           :
    (regSel == `LB_REG_POL_LO)   ? polarity[7:0]          :
    (regSel == `LB_REG_POL_HI)   ? polarity[15:8]         :
    (regSel == `LB_REG_STATUS)   ? statusByte             :
    (regSel == `LB_REG_IN_LO)    ? ifc.synced[7:0]        :
    (regSel == `LB_REG_IN_HI)    ? ifc.synced[15:8]       :
    (regSel == `LB_REG_CTRL)     ? ctrlByte               :
    (regSel == `LB_REG_ACT_LO)   ? ifc.gated[7:0]         :
    (regSel == `LB_REG_ACT_HI)   ? ifc.gated[15:8]        :
    (regSel == `LB_REG_CNT_LO)   ? pauseCount[7:0]        :
    (regSel == `LB_REG_CNT_HI)   ? pauseCount[15:8]       :
                                   `LB_BYTE_ZERO;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk) begin
    if (reset) begin
      wbAck    <= 1'h0;
      wbDatOut <= {`LB_WORD_PAD, `LB_BYTE_ZERO};
    end else begin
      wbAck    <= rdTake;
      if (rdTake) begin
        wbDatOut <= {`LB_WORD_PAD, rdByte};
      end
    end
  end

  // RULE2 low byte staged, high byte commits all
  always_ff @(posedge mclk) begin
    if (reset) begin
      enStage  <= `LB_BYTE_ZERO;
      polStage <= `LB_BYTE_ZERO;
      enable   <= `LB_EN_RST;
      polarity <= `LB_POL_RST;
    end else begin
      if (wrEnLo) begin
        enStage <= wrByte;
      end
      if (wrEnHi) begin
        enable <= {wrByte, enStage};
      end
      if (wrPolLo) begin
        polStage <= wrByte;
      end
      if (wrPolHi) begin
        polarity <= {wrByte, polStage};
      end
    end
  end

  // RULE1 init makes every connector an input
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrlRun   <= 1'h0;
      connInput <= `LB_CONN_RST;
    end else begin
      if (wrCtrl) begin
        ctrlRun <= wrByte[`LB_CTRL_RUN];
      end
      if (initCmd) begin
        connInput <= `LB_CONN_ALL;
      end
    end
  end

  // RULE7 common local inhibit
  always_ff @(posedge mclk) begin
    if (reset) begin
      localBlank <= 1'h0;
    end else begin
      localBlank <= |ifc.gated;
    end
  end

  // RULE11 local checked before global
  always_comb begin
    if (!ctrlRun) begin
      next_state = ACQ_IDLE;
    end else if (localBlank) begin
      next_state = ACQ_PAUSED;
    end else if (globalBlank) begin
      next_state = ACQ_DISABLED;
    end else begin
      next_state = ACQ_RUN;
    end
  end

  // RULE9 resume keeps frame, RULE10 restart after disable
  always_comb begin
    next_integRestart = 1'h0;
    next_frameResume  = 1'h0;
    unique case (state)
      ACQ_IDLE: begin
        next_integRestart = (next_state == ACQ_RUN);
      end
      ACQ_RUN: begin
      end
      ACQ_PAUSED: begin
        next_frameResume = (next_state == ACQ_RUN);
      end
      ACQ_DISABLED: begin
        next_integRestart = (next_state == ACQ_RUN);
      end
    endcase
  end

  // RULE8 pause state and episode count
  always_ff @(posedge mclk) begin
    if (reset) begin
      state        <= ACQ_IDLE;
      integRestart <= 1'h0;
      frameResume  <= 1'h0;
      pauseCount   <= `LB_CNT_RST;
    end else begin
      state        <= next_state;
      integRestart <= next_integRestart;
      frameResume  <= next_frameResume;
      if (next_state == ACQ_PAUSED && state != ACQ_PAUSED) begin
        pauseCount <= pauseCount + 16'h0001;
      end
    end
  end

  assign acqRun      = (state == ACQ_RUN);
  assign acqPaused   = (state == ACQ_PAUSED);
  assign acqDisabled = (state == ACQ_DISABLED);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_init_inputs: assert property (   // RULE1
    initCmd |=> (connInput == `LB_CONN_ALL))
    else $error("init did not make all connectors inputs");

  a_enable_commit: assert property (   // RULE2
    wrEnHi |=> (enable == {$past(wrByte), $past(enStage)}))
    else $error("enable word not committed from staged byte");

  a_enable_hold: assert property (   // RULE2
    !wrEnHi |=> $stable(enable))
    else $error("enable changed without a high byte write");

  a_read_back: assert property (   // RULE6
    (rdTake && cardHit && regSel == `LB_REG_POL_HI)
      |=> wbAck && (wbDatOut[7:0] == $past(polarity[15:8])))
    else $error("polarity high byte read back wrong");

  a_unmapped_zero: assert property (   // RULE12
    (rdTake && !cardHit) |=> wbAck && (wbDatOut == 32'h00000000))
    else $error("foreign card read did not answer zero");

  a_or_inhibit: assert property (   // RULE7
    localBlank == $past(|ifc.gated))
    else $error("common inhibit is not the OR of gated inputs");

  a_local_pause: assert property (   // RULE8
    (ctrlRun && localBlank) |=> acqPaused && !acqRun)
    else $error("local inhibit did not pause acquisition");

  a_local_priority: assert property (   // RULE11
    (ctrlRun && localBlank && globalBlank) |=> acqPaused && !acqDisabled)
    else $error("global blanking overrode local inhibit");

  a_resume_frame: assert property (   // RULE9
    (acqPaused && ctrlRun && !localBlank && !globalBlank)
      |=> acqRun && frameResume && !integRestart)
    else $error("resume after local inhibit started a new frame");

  a_restart_now: assert property (   // RULE10
    (acqDisabled && ctrlRun && !localBlank && !globalBlank)
      |=> acqRun && integRestart ##1 !integRestart)
    else $error("integration did not restart after global blanking");

  a_global_disable: assert property (   // RULE10
    (ctrlRun && !localBlank && globalBlank) |=> acqDisabled)
    else $error("global blanking did not disable acquisition");

  a_ack_pulse: assert property (   // RULE12
    wbAck |=> !wbAck)
    else $error("bus acknowledge held longer than one cycle");

  a_pause_count: assert property (   // RULE8
    $rose(acqPaused) |-> (pauseCount == $past(pauseCount) + 16'h0001))
    else $error("pause episode was not counted");

  c_pause_resume: cover property (
    acqRun ##1 acqPaused [*2] ##1 frameResume);
  c_global_restart: cover property (
    acqDisabled ##1 integRestart);
  c_both_blanks: cover property (
    localBlank && globalBlank && acqPaused);
  c_enable_commit: cover property (
    wrEnLo ##[1:20] wrEnHi);
  c_foreign_read: cover property (
    rdTake && !cardHit);

endmodule : local_blanking_control

// *** dv/blank_source_model.sv ***
/*
  Far-side model: front-panel inhibit sources of eight cards.
  Assumes the bench changes connector levels just after a clock edge.
*/
`timescale 1ns/100ps

module blank_source_model (
  input  wire logic        mclk,
  input  wire logic [7:0]  firstConn,
  input  wire logic [7:0]  secondConn,
  input  wire logic [3:0]  lag,
  output logic      [15:0] extBlank
);
  logic [15:0] pairs;
  logic [3:0]  waitCnt = 4'h0;

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pairs[2*k +: 2] = {secondConn[k], firstConn[k]};
    end
  end

  // slow source keeps old level for lag cycles
  always @(posedge mclk) begin
    if (pairs != extBlank && waitCnt < lag) begin
      waitCnt <= waitCnt + 4'h1;
    end else begin
      waitCnt  <= 4'h0;
      extBlank <= pairs;
    end
  end

  initial extBlank = 16'h0000;
endmodule : blank_source_model

// *** dv/test_local_blanking_control.sv ***
/*
  Self-checking bench: settings table, readback, priority and pulses.
  Assumes the design answers every Wishbone request with one ack.
*/
`timescale 1ns/100ps

module test_local_blanking_control
  import lblank_pkg::*;
;
  typedef struct {
    logic [15:0] en, pol;
    logic [7:0]  fc, sc;
    logic        g, l;
    logic [2:0]  st;
  } row_t;

  logic        mclk = 1'h0, reset = 1'h1, globalBlank = 1'h0;
  logic        wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0, wbAck;
  logic [9:0]  wbAdr = 10'h000;
  logic [3:0]  wbSel = 4'h0, lag = 4'h0;
  logic [31:0] wbDatIn = 32'h0, wbDatOut;
  logic [15:0] extBlank, connInput, v, w;
  logic [7:0]  fc = 8'h00, sc = 8'h00, b;
  logic        localBlank, acqRun, acqPaused, acqDisabled;
  logic        integRestart, frameResume;
  int          errorCnt = 0, nTests = 0, cyc = 0, rsm = 0, rst = 0, r0, s0;
  row_t rows [9] = '{
    '{16'h0000, 16'h0000, 8'h00, 8'h00, 1'h0, 1'h0, 3'h1},
    '{16'h0001, 16'h0000, 8'h00, 8'h00, 1'h0, 1'h1, 3'h2},
    '{16'h0001, 16'h0001, 8'h00, 8'h00, 1'h0, 1'h0, 3'h1},
    '{16'h0002, 16'hffff, 8'h00, 8'h01, 1'h0, 1'h1, 3'h2},
    '{16'h8000, 16'hffff, 8'hff, 8'h80, 1'h1, 1'h1, 3'h2},
    '{16'h8000, 16'hffff, 8'hff, 8'h7f, 1'h1, 1'h0, 3'h4},
    '{16'hffff, 16'h0000, 8'hff, 8'hff, 1'h0, 1'h0, 3'h1},
    '{16'h5a5a, 16'h5a5a, 8'h00, 8'h00, 1'h0, 1'h0, 3'h1},
    '{16'hffff, 16'ha5a5, 8'h00, 8'h00, 1'h0, 1'h1, 3'h2}};

  always #50 mclk = ~mclk;

  local_blanking_control i_dut (.mclk(mclk), .reset(reset), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .extBlank(extBlank), .globalBlank(globalBlank),
    .localBlank(localBlank), .acqRun(acqRun), .acqPaused(acqPaused),
    .acqDisabled(acqDisabled), .integRestart(integRestart),
    .frameResume(frameResume), .connInput(connInput));

  blank_source_model i_src (.mclk(mclk), .firstConn(fc), .secondConn(sc),
    .lag(lag), .extBlank(extBlank));

  always @(posedge mclk) begin
    rsm <= rsm + int'(frameResume === 1'h1);
    rst <= rst + int'(integRestart === 1'h1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errorCnt++;
      endSim();
    end
  end

  task automatic endSim();
    $display("checks %0d, errors %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : endSim

  task automatic chk_val(string what, logic [15:0] e, logic [15:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("wrong value %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(string what, logic e, logic g);
    chk_val(what, {15'h0, e}, {15'h0, g});
  endtask : chk_bit

  task automatic wb(logic we, logic [7:0] idx, logic [7:0] d,
                    output logic [7:0] rd);
    @(posedge mclk);
    wbCyc   <= 1'h1;
    wbStb   <= 1'h1;
    wbWe    <= we;
    wbSel   <= 4'hf;
    wbAdr   <= {idx, 2'h0};
    wbDatIn <= {24'h0, d};
    @(posedge mclk);
    while (wbAck !== 1'h1) @(posedge mclk);
    rd = wbDatOut[7:0];
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
  endtask : wb

  task automatic set16(logic [7:0] lo, logic [15:0] d);
    wb(1'h1, lo, d[7:0], b);
    wb(1'h1, lo + 8'h01, d[15:8], b);
  endtask : set16

  task automatic rd16(logic [7:0] lo, output logic [15:0] d);
    wb(1'h0, lo, 8'h00, d[7:0]);
    wb(1'h0, lo + 8'h01, 8'h00, d[15:8]);
  endtask : rd16

  task automatic chk_acq(logic [2:0] e);
    chk_val("acqState", {13'h0, e}, {13'h0, acqDisabled, acqPaused, acqRun});
  endtask : chk_acq

  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    #1 chk_val("connInput", 16'h0000, connInput);
    chk_bit("localBlank", 1'h0, localBlank);
    chk_acq(3'h0);
    wb(1'h1, 8'h07, 8'h03, b);
    repeat (2) @(posedge mclk);
    chk_val("connInput", 16'hffff, connInput);
    foreach (rows[i]) begin
      set16(8'h00, rows[i].en);
      set16(8'h02, rows[i].pol);
      rd16(8'h00, v);
      chk_val("enable", rows[i].en, v);
      rd16(8'h02, v);
      chk_val("polarity", rows[i].pol, v);
      fc <= rows[i].fc;
      sc <= rows[i].sc;
      globalBlank <= rows[i].g;
      repeat (8) @(posedge mclk);
      #1 chk_bit("localBlank", rows[i].l, localBlank);
      chk_acq(rows[i].st);
    end
    wb(1'h1, 8'h00, 8'h00, b);
    rd16(8'h00, v);
    chk_val("staged enable", 16'hffff, v);
    wb(1'h1, 8'h11, 8'h00, b);
    wb(1'h0, 8'h10, 8'h00, b);
    chk_val("other card", 16'h0000, {8'h00, b});
    rd16(8'h00, v);
    chk_val("enable kept", 16'hffff, v);
    set16(8'h02, 16'hffff);
    rd16(8'h0a, w);
    repeat (6) @(posedge mclk);
    fc <= 8'h01;
    repeat (3) @(posedge mclk);
    #1 chk_bit("early localBlank", 1'h0, localBlank);
    repeat (2) @(posedge mclk);
    #1 chk_bit("synced localBlank", 1'h1, localBlank);
    rd16(8'h0a, v);
    chk_val("pause count", w + 16'h0001, v);
    wb(1'h0, 8'h04, 8'h00, b);
    chk_val("status", 16'h0029, {8'h00, b});
    wb(1'h0, 8'h05, 8'h00, b);
    chk_val("synced inputs", 16'h0001, {8'h00, b});
    wb(1'h0, 8'h08, 8'h00, b);
    chk_val("gated inputs", 16'h0001, {8'h00, b});
    wb(1'h0, 8'h07, 8'h00, b);
    chk_val("control", 16'h0001, {8'h00, b});
    r0 = rsm;
    s0 = rst;
    lag <= 4'h4;
    fc <= 8'h00;
    repeat (14) @(posedge mclk);
    #1 chk_val("resume pulses", 16'(r0 + 1), 16'(rsm));
    chk_val("restart pulses", 16'(s0), 16'(rst));
    @(posedge mclk);
    globalBlank <= 1'h1;
    repeat (4) @(posedge mclk);
    #1 chk_acq(3'h4);
    @(posedge mclk);
    globalBlank <= 1'h0;
    repeat (4) @(posedge mclk);
    #1 chk_val("restart pulses", 16'(s0 + 1), 16'(rst));
    chk_acq(3'h1);
    @(posedge mclk);
    reset <= 1'h1;
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    #1 chk_val("connInput", 16'h0000, connInput);
    chk_bit("localBlank", 1'h0, localBlank);
    chk_acq(3'h0);
    rd16(8'h00, v);
    chk_val("enable after reset", 16'h0000, v);
    rd16(8'h02, v);
    chk_val("polarity after reset", 16'h0000, v);
    endSim();
  end
endmodule : test_local_blanking_control
